/* hw/vtos_top.sv */
// Option settings controller for the timing and video option banks
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module vtos_top
  import vtos_pkg::*;
#(
  parameter int unsigned HOLD_CNT = vtos_pkg::HOLD_CYCLES,
  parameter int unsigned DEBOUNCE_CNT = vtos_pkg::DEBOUNCE_CYCLES
)
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Operator switches (asynchronous pins)
  input wire logic [3:0] function_selector_i,
  input wire logic value_toggle_up_i,
  input wire logic value_toggle_down_i,
  // Card straps and video status
  input wire logic pal625_i,
  input wire logic frame_sync_variant_i,
  input wire logic input_present_i,
  // Non-volatile store, same clock
  input wire logic nvm_load_i,
  input wire logic [vtos_pkg::IMG_W-1:0] nvm_rdata_i,
  output logic nvm_save_o,
  output logic [vtos_pkg::IMG_W-1:0] nvm_wdata_o,
  // Avalon-MM slave
  input wire logic [1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Settings to the video pipeline
  output logic [vtos_pkg::IMG_W-1:0] settings_o,
  output logic freeze_active_o,
  output logic output_black_o,
  output logic output_mute_o,
  output logic force_mono_o,
  output logic [2:0] bank_o
);
  import vtos_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Saturating step over codes 0..2, up increments
  function automatic logic [1:0] step3(input logic [1:0] v, input logic up);
    if (up)
      step3 = (v == 2'h2) ? v : 2'(v + 2'h1);
    else
      step3 = (v == 2'h0) ? v : 2'(v - 2'h1);
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [5:0] sync1_q; // First stage, read only by second
  logic [5:0] sync2_q; // Stable synchronised pins
  // Two flops per pin before any logic looks at it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end
    else if (ce_i)
    begin
      sync1_q <= {function_selector_i, value_toggle_down_i, value_toggle_up_i};
      sync2_q <= sync1_q;
    end
  end

  wire [3:0] fsel = sync2_q[5:2]; // Selector position
  wire [1:0] raw_tog = sync2_q[1:0]; // {down, up}

  // ------------------------------------------------------------
  // Toggle debounce and hold detection
  // ------------------------------------------------------------
  logic [1:0] tog_q; // Debounced toggle state
  logic [1:0] cand_q; // Candidate awaiting stability
  logic [31:0] deb_q; // Stability counter
  logic [31:0] hold_q; // Hold duration counter
  logic press_q; // One-cycle press event
  logic held_q; // One-cycle hold event
  logic dir_up_q; // Direction of last event

  // Contact bounce is ignored; both directions at once raises no press event
  wire tog_valid = (cand_q == 2'b01) || (cand_q == 2'b10);
  wire deb_done = (deb_q >= DEBOUNCE_CNT - 1);
  wire hold_done = (hold_q == HOLD_CNT - 1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tog_q <= 2'b00;
      cand_q <= 2'b00;
      deb_q <= 32'h0;
      hold_q <= 32'h0;
      press_q <= 1'b0;
      held_q <= 1'b0;
      dir_up_q <= 1'b0;
    end
    else if (ce_i)
    begin
      press_q <= 1'b0;
      held_q <= 1'b0;
      // Restart the stability timer on any change
      if (raw_tog != cand_q)
      begin
        cand_q <= raw_tog;
        deb_q <= 32'h0;
      end
      else if (!deb_done)
        deb_q <= deb_q + 32'h1;
      else if (tog_q != cand_q)
      begin
        tog_q <= cand_q;
        hold_q <= 32'h0;
        // Only a fresh press from rest raises an event
        if (tog_valid && (tog_q == 2'b00))
        begin
          press_q <= 1'b1;
          dir_up_q <= cand_q[0];
        end
      end
      else if ((tog_q != 2'b00) && !hold_done)
      begin
        hold_q <= hold_q + 32'h1;
        if (hold_q == HOLD_CNT - 2)
          held_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Settings state
  // ------------------------------------------------------------
  vtos_bank_t bank_q; // Active bank
  logic setup_q; // Black setup on
  logic viblank_q; // Blank vertical interval
  logic [5:0] viend_q; // Vertical interval last line
  logic below_q; // Below-black pass (1) or clip (0)
  logic vbit_q; // Bit lock on line 20 (1) or 10 (0)
  logic [1:0] tmode_q; // Timing mode
  logic inmode_q; // Tape-machine input handling
  logic [1:0] frz_q; // Freeze scope
  logic [1:0] loss_q; // Input loss response
  logic [1:0] hotsw_q; // Hotswitch response
  logic force_frz_q; // Forced freeze, volatile
  logic force_blk_q; // Forced black, volatile
  logic force_mono_q; // Forced mono, volatile
  logic variant_q; // Captured variant strap
  logic dirty_q; // Stored image changed
  logic first_q; // First enabled edge after reset, straps not yet caught

  // Addressed position decode
  wire at_bank = press_q && (fsel == POS_BANK);
  wire in_b = press_q && (fsel != POS_BANK) && (bank_q == VTOS_BANK_B);
  wire in_c = press_q && (fsel != POS_BANK) && (bank_q == VTOS_BANK_C);
  wire held_c = held_q && (bank_q == VTOS_BANK_C);
  wire up = dir_up_q;

  wire [1:0] tm_up = (tmode_q == TM_LINE_DELAY) ? (variant_q ? TM_FRAME_SYNC : TM_LINE_SYNC) :
                     2'(tmode_q + 2'h1);
  wire [1:0] tm_dn = (tmode_q == TM_FRAME_SYNC) ? TM_LINE_DELAY :
                     (!variant_q && tmode_q == TM_LINE_SYNC) ? TM_LINE_DELAY : 2'(tmode_q - 2'h1);
  wire [1:0] tm_def = frame_sync_variant_i ? TM_FRAME_SYNC : TM_LINE_SYNC;

  // Current stored image
  wire [IMG_W-1:0] image = {hotsw_q, loss_q, frz_q, inmode_q, tmode_q, vbit_q, below_q, viend_q,
                            viblank_q, setup_q};

  // Register bus write strobe
  logic wait_q;
  wire avs_req = avs_read_i || avs_write_i;
  wire avs_done = avs_req && !wait_q;
  wire sw_wr = avs_done && avs_write_i && (avs_address_i == REG_SETTINGS);
  wire [IMG_W-1:0] wimg = avs_writedata_i[IMG_W-1:0];

  // Restored image with out-of-range codes kept legal
  wire [IMG_W-1:0] limg = sw_wr ? wimg : nvm_rdata_i;
  wire load_img = nvm_load_i || sw_wr;
  wire [1:0] ld_tm = limg[F_TMODE+1:F_TMODE];
  wire ld_tm_ok = variant_q || ld_tm[1];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bank_q <= VTOS_BANK_A;
      setup_q <= 1'b0;
      viblank_q <= 1'b0;
      viend_q <= VERTICAL_INTERVAL_LAST_LINE_RESET;
      below_q <= 1'b1;
      vbit_q <= 1'b1;
      tmode_q <= TM_LINE_SYNC;
      inmode_q <= 1'b0;
      frz_q <= FRZ_FIELD1;
      loss_q <= LOSS_BLACK;
      hotsw_q <= HSW_OFF;
      force_frz_q <= 1'b0;
      force_blk_q <= 1'b0;
      force_mono_q <= 1'b0;
      variant_q <= 1'b0;
      // No save on power-up, so the stored image survives until it is restored
      dirty_q <= 1'b0;
      first_q <= 1'b1;
    end
    else if (ce_i)
    begin
      // First cycle after release: straps captured, defaults per standard
      first_q <= 1'b0;
      if (first_q)
      begin
        variant_q <= frame_sync_variant_i;
        setup_q <= pal625_i;
        tmode_q <= tm_def;
      end
      dirty_q <= 1'b0;
      if (load_img)
      begin
        setup_q <= limg[F_SETUP];
        viblank_q <= limg[F_VIBLANK];
        viend_q <= (limg[F_VIEND+5:F_VIEND] < VERTICAL_INTERVAL_LAST_LINE_MIN) ? VERTICAL_INTERVAL_LAST_LINE_MIN : limg[F_VIEND+5:F_VIEND];
        below_q <= limg[F_BELOW];
        vbit_q <= limg[F_VBIT];
        tmode_q <= ld_tm_ok ? ld_tm : TM_LINE_SYNC;
        inmode_q <= limg[F_INMODE];
        frz_q <= (limg[F_FRZ+1:F_FRZ] == 2'h3) ? FRZ_FIELD1 : limg[F_FRZ+1:F_FRZ];
        loss_q <= (limg[F_LOSS+1:F_LOSS] == 2'h3) ? LOSS_BLACK : limg[F_LOSS+1:F_LOSS];
        hotsw_q <= (limg[F_HOTSW+1:F_HOTSW] == 2'h3) ? HSW_OFF : limg[F_HOTSW+1:F_HOTSW];
        dirty_q <= sw_wr;
      end
      else if (at_bank)
      begin
        case (bank_q)
          VTOS_BANK_A: bank_q <= up ? VTOS_BANK_A : VTOS_BANK_B;
          VTOS_BANK_B: bank_q <= up ? VTOS_BANK_A : VTOS_BANK_C;
          VTOS_BANK_C: bank_q <= up ? VTOS_BANK_B : VTOS_BANK_C;
          default: bank_q <= VTOS_BANK_A;
        endcase
      end
      else if (in_b)
      begin
        dirty_q <= 1'b1;
        case (fsel)
          POS_B_SETUP: setup_q <= up;
          POS_B_VIBLANK: viblank_q <= up;
          POS_B_VIEND:
            if (up && viend_q != VERTICAL_INTERVAL_LAST_LINE_MAX)
              viend_q <= viend_q + 6'h01;
            else if (!up && viend_q != VERTICAL_INTERVAL_LAST_LINE_MIN)
              viend_q <= viend_q - 6'h01;
          POS_B_BELOW: below_q <= up;
          POS_B_VBIT: vbit_q <= up;
          default: dirty_q <= 1'b0;
        endcase
      end
      else if (in_c)
      begin
        dirty_q <= 1'b1;
        case (fsel)
          POS_C_TMODE: tmode_q <= up ? tm_up : tm_dn;
          POS_C_INMODE: inmode_q <= up;
          POS_C_FRZ: frz_q <= step3(frz_q, up);
          POS_C_FORCE:
          begin
            force_frz_q <= up;
            dirty_q <= 1'b0;
          end
          POS_C_LOSS: loss_q <= step3(loss_q, up);
          // Hotswitch steps up toward freeze
          POS_C_HOTSW: hotsw_q <= step3(hotsw_q, up);
          // Turning off needs no hold
          POS_C_BLACK:
          begin
            if (!up)
              force_blk_q <= 1'b0;
            dirty_q <= 1'b0;
          end
          POS_C_MONO:
          begin
            if (!up)
              force_mono_q <= 1'b0;
            dirty_q <= 1'b0;
          end
          default: dirty_q <= 1'b0;
        endcase
      end
      else if (held_c && up && fsel == POS_C_BLACK)
        force_blk_q <= 1'b1;
      else if (held_c && up && fsel == POS_C_MONO)
        force_mono_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Outputs to the pipeline and the store
  // ------------------------------------------------------------
  logic lost_q; // Input absence, synchronised
  logic lost1_q; // First stage, read only by lost_q
  wire lost_frz = lost_q && (loss_q == LOSS_FREEZE);
  // Outputs registered so the pipeline sees glitch-free levels
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lost1_q <= 1'b0;
      lost_q <= 1'b0;
      nvm_save_o <= 1'b0;
      nvm_wdata_o <= '0;
      settings_o <= '0;
      freeze_active_o <= 1'b0;
      output_black_o <= 1'b0;
      output_mute_o <= 1'b0;
      force_mono_o <= 1'b0;
      bank_o <= VTOS_BANK_A;
    end
    else if (ce_i)
    begin
      lost1_q <= !input_present_i;
      lost_q <= lost1_q;
      // Save pulse follows any panel or bus change of a stored setting; restores and strap defaults do not save
      nvm_save_o <= dirty_q;
      nvm_wdata_o <= image;
      settings_o <= image;
      freeze_active_o <= force_frz_q || lost_frz;
      output_black_o <= force_blk_q || (lost_q && loss_q == LOSS_BLACK);
      output_mute_o <= lost_q && (loss_q == LOSS_NO_OUTPUT);
      force_mono_o <= force_mono_q;
      bank_o <= bank_q;
    end
  end

  // ------------------------------------------------------------
  // Avalon-MM slave: one wait state on every access
  // ------------------------------------------------------------
  wire [31:0] status_word = {25'h0, variant_q, lost_q, force_mono_q, force_blk_q, force_frz_q, tog_q[1], tog_q[0]};
  wire [31:0] rd_mux = (avs_address_i == REG_SETTINGS) ? {13'h0, image} :
                       (avs_address_i == REG_STATUS) ? status_word : 32'h0;
  // Read data captured in the wait cycle, stands when waitrequest drops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wait_q <= 1'b1;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
    end
    else if (ce_i)
    begin
      wait_q <= !(avs_req && wait_q);
      avs_waitrequest_o <= !(avs_req && wait_q);
      if (avs_req && wait_q)
        avs_readdata_o <= rd_mux;
    end
  end

endmodule

/* common/vtos_pkg.sv */
// Constants and types for the video timing option settings block
package vtos_pkg;
  // Timing
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned HOLD_TIME_MS = 1000;
  localparam int unsigned DEBOUNCE_TIME_MS = 10;
  localparam int unsigned HOLD_CYCLES = (CLK_HZ / 1000) * HOLD_TIME_MS;
  localparam int unsigned DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_TIME_MS;
  // Selector positions
  localparam logic [3:0] POS_BANK = 4'h0;
  localparam logic [3:0] POS_B_SETUP = 4'h1;
  localparam logic [3:0] POS_B_VIBLANK = 4'h3;
  localparam logic [3:0] POS_B_VIEND = 4'h4;
  localparam logic [3:0] POS_B_BELOW = 4'h5;
  localparam logic [3:0] POS_B_VBIT = 4'h6;
  localparam logic [3:0] POS_C_TMODE = 4'h1;
  localparam logic [3:0] POS_C_INMODE = 4'h7;
  localparam logic [3:0] POS_C_FRZ = 4'h8;
  localparam logic [3:0] POS_C_FORCE = 4'h9;
  localparam logic [3:0] POS_C_LOSS = 4'hA;
  localparam logic [3:0] POS_C_HOTSW = 4'hB;
  localparam logic [3:0] POS_C_BLACK = 4'hC;
  localparam logic [3:0] POS_C_MONO = 4'hD;
  // Timing mode codes
  localparam logic [1:0] TM_FRAME_SYNC = 2'h0;
  localparam logic [1:0] TM_FRAME_DELAY = 2'h1;
  localparam logic [1:0] TM_LINE_SYNC = 2'h2;
  localparam logic [1:0] TM_LINE_DELAY = 2'h3;
  // Freeze scope, input loss and hotswitch codes
  localparam logic [1:0] FRZ_FIELD1 = 2'h0;
  localparam logic [1:0] FRZ_FIELD2 = 2'h1;
  localparam logic [1:0] FRZ_FRAME = 2'h2;
  localparam logic [1:0] LOSS_BLACK = 2'h0;
  localparam logic [1:0] LOSS_NO_OUTPUT = 2'h1;
  localparam logic [1:0] LOSS_FREEZE = 2'h2;
  localparam logic [1:0] HSW_OFF = 2'h0;
  localparam logic [1:0] HSW_BLACK = 2'h1;
  localparam logic [1:0] HSW_FREEZE = 2'h2;
  // Vertical interval last line
  localparam logic [5:0] VERTICAL_INTERVAL_LAST_LINE_RESET = 6'h14;
  localparam logic [5:0] VERTICAL_INTERVAL_LAST_LINE_MIN = 6'h0A;
  localparam logic [5:0] VERTICAL_INTERVAL_LAST_LINE_MAX = 6'h3F;
  // Memory-backed image layout
  localparam int IMG_W = 19;
  localparam int F_SETUP = 0;
  localparam int F_VIBLANK = 1;
  localparam int F_VIEND = 2;
  localparam int F_BELOW = 8;
  localparam int F_VBIT = 9;
  localparam int F_TMODE = 10;
  localparam int F_INMODE = 12;
  localparam int F_FRZ = 13;
  localparam int F_LOSS = 15;
  localparam int F_HOTSW = 17;
  // Register word indices
  localparam logic [1:0] REG_SETTINGS = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  // Bank selection, one-hot
  typedef enum logic [2:0] {
    VTOS_BANK_A = 3'b001,
    VTOS_BANK_B = 3'b010,
    VTOS_BANK_C = 3'b100
  } vtos_bank_t;
endpackage

/* verification/vtos_properties.sv */
// Port checker of the option settings controller, with its bind
`timescale 1ns/1ps
module vtos_properties
  import vtos_pkg::*;
(
  // Clock and reset
  input logic clk_i,
  input logic rst_i,
  // Watched inputs
  input logic value_toggle_up_i,
  input logic value_toggle_down_i,
  input logic [3:0] function_selector_i,
  input logic frame_sync_variant_i,
  input logic input_present_i,
  input logic nvm_load_i,
  input logic [vtos_pkg::IMG_W-1:0] nvm_rdata_i,
  input logic [1:0] avs_address_i,
  input logic avs_read_i,
  input logic avs_write_i,
  // Watched outputs
  input logic avs_waitrequest_o,
  input logic nvm_save_o,
  input logic [vtos_pkg::IMG_W-1:0] settings_o,
  input logic output_mute_o,
  input logic [2:0] bank_o
);
  logic [1:0] rcnt_q; // Edges since reset, saturating
  logic [3:0] idle_q; // Cycles with toggles, bus requests and restore load all quiet
  logic [3:0] selnz_q; // Cycles away from the bank position
  logic [2:0] pres_q; // Cycles with video present
  logic [IMG_W-1:0] ld_q; // Last image restored
  wire quiet = !(value_toggle_up_i || value_toggle_down_i || avs_read_i || avs_write_i || nvm_load_i);
  // Saturating counters; long holds are judged on these, not on repetition
  always_ff @(posedge clk_i)
  begin
    rcnt_q <= rst_i ? 2'h0 : rcnt_q + 2'(rcnt_q != 2'h3);
    idle_q <= (rst_i || !quiet) ? 4'h0 : idle_q + 4'(idle_q != 4'hF);
    selnz_q <= (rst_i || function_selector_i == POS_BANK) ? 4'h0 : selnz_q + 4'(selnz_q != 4'hF);
    pres_q <= (rst_i || !input_present_i) ? 3'h0 : pres_q + 3'(pres_q != 3'h7);
    if (nvm_load_i)
      ld_q <= nvm_rdata_i;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("wait state not exactly one cycle");
  AST_WRITE_SAVES: assert property (avs_write_i && !avs_waitrequest_o && avs_address_i == REG_SETTINGS
    |-> ##[1:3] nvm_save_o) else $error("image write not stored");
  AST_SAVE_PULSE: assert property (nvm_save_o |=> !nvm_save_o) else $error("store pulse too long");
  AST_LOAD_APPLIES: assert property (nvm_load_i && rcnt_q == 2'h3
    |-> ##[1:3] settings_o == ld_q) else $error("restored image not applied");
  AST_LINE_RANGE: assert property (rcnt_q == 2'h3 |-> settings_o[7:2] >= VERTICAL_INTERVAL_LAST_LINE_MIN)
    else $error("last line below range");
  AST_CODES_LEGAL: assert property (rcnt_q == 2'h3 |-> settings_o[14:13] != 2'h3
    && settings_o[16:15] != 2'h3 && settings_o[18:17] != 2'h3) else $error("illegal mode code");
  AST_BASE_NO_FRAME: assert property (rcnt_q == 2'h3 && !frame_sync_variant_i |-> settings_o[11])
    else $error("frame timing on base variant");
  AST_MUTE_NEEDS_LOSS: assert property (pres_q == 3'h7 |-> !output_mute_o)
    else $error("muted with input present");
  AST_SETTINGS_HOLD: assert property (idle_q == 4'hF |-> $stable(settings_o))
    else $error("settings moved without a request");
  AST_BANK_ONEHOT: assert property ($onehot(bank_o)) else $error("bank not one-hot");
  AST_BANK_STABLE: assert property (selnz_q == 4'hF |-> $stable(bank_o))
    else $error("bank moved away from position zero");
endmodule
bind vtos_top vtos_properties vtos_properties_inst (.clk_i, .rst_i, .value_toggle_up_i,
  .value_toggle_down_i, .function_selector_i, .frame_sync_variant_i, .input_present_i, .nvm_load_i,
  .nvm_rdata_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .nvm_save_o,
  .settings_o, .output_mute_o, .bank_o);

/* verification/vtos_panel.sv */
// Operator panel model: rotary selector and bouncing lever toggle
`timescale 1ns/1ps
module vtos_panel
(
  // Clock
  input wire logic clk_i,
  // Commands from the bench
  input wire logic [3:0] pos_i,
  input wire logic [1:0] press_i,
  // Switch contacts to the card
  output logic [3:0] function_selector_o,
  output logic up_o,
  output logic down_o
);
  logic [1:0] last_q = 2'h0; // Lever position last cycle
  logic [1:0] moved_q = 2'h0; // Contacts that just moved
  logic [1:0] bounce_q = 2'h0; // Chatter cycles left
  // Every lever move chatters a few cycles; the card has to ride it out
  always_ff @(posedge clk_i)
  begin
    last_q <= press_i;
    if (press_i != last_q)
      moved_q <= press_i ^ last_q;
    bounce_q <= (press_i != last_q) ? 2'h3 : bounce_q - 2'(bounce_q != 2'h0);
  end
  // selector stays where the operator left it
  assign function_selector_o = pos_i;
  // contacts follow the lever, but open and close while bounce_q counts down after a move
  assign up_o = press_i[0] ^ (bounce_q[0] & moved_q[0]);
  assign down_o = press_i[1] ^ (bounce_q[0] & moved_q[1]);
endmodule

/* verification/vtos_top_tb.sv */
// Self-checking bench of the option settings controller
`timescale 1ns/1ps
module vtos_top_tb;
  import vtos_pkg::*;
  localparam logic [1:0] UP = 2'h1; // Lever up
  localparam logic [1:0] DN = 2'h2; // Lever down
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic pal625_i = 1'b1;
  logic frame_sync_variant_i = 1'b1;
  logic input_present_i = 1'b1;
  logic nvm_load_i = 1'b0;
  logic [IMG_W-1:0] nvm_rdata_i = '0;
  logic [1:0] avs_address_i = 2'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] pos = 4'h0; // Commanded selector position
  logic [1:0] press = 2'h0; // Commanded lever
  logic [3:0] sel;
  logic up;
  logic dn;
  logic nvm_save_o, avs_waitrequest_o, freeze_active_o, output_black_o, output_mute_o, force_mono_o;
  logic [IMG_W-1:0] nvm_wdata_o, settings_o;
  logic [31:0] avs_readdata_o;
  logic [2:0] bank_o;
  logic [18:0] e; // Expected image
  logic [31:0] q; // Last read data
  logic [31:0] seed = 32'h0000F757;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  // Short counts keep the hold and debounce tests brief
  vtos_top #(.HOLD_CNT(20), .DEBOUNCE_CNT(3)) vtos_top_inst (.clk_i, .rst_i, .ce_i,
    .function_selector_i(sel), .value_toggle_up_i(up), .value_toggle_down_i(dn), .pal625_i,
    .frame_sync_variant_i, .input_present_i, .nvm_load_i, .nvm_rdata_i, .nvm_save_o, .nvm_wdata_o,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .settings_o, .freeze_active_o, .output_black_o, .output_mute_o, .force_mono_o, .bank_o);
  vtos_panel vtos_panel_inst (.clk_i, .pos_i(pos), .press_i(press), .function_selector_o(sel),
    .up_o(up), .down_o(dn));
  initial forever #5 clk_i = ~clk_i;
  // Xorshift source, fixed start
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Power-up image from the straps
  function automatic logic [18:0] f_def(input logic p, input logic v);
    return {7'h00, v ? TM_FRAME_SYNC : TM_LINE_SYNC, 2'b11, VERTICAL_INTERVAL_LAST_LINE_RESET, 1'b0, p};
  endfunction
  // Image after the card coerces a written one
  function automatic logic [18:0] f_fix(input logic [18:0] r, input logic v);
    if (r[7:2] < VERTICAL_INTERVAL_LAST_LINE_MIN)
      r[7:2] = VERTICAL_INTERVAL_LAST_LINE_MIN;
    if (!v && !r[11])
      r[11:10] = TM_LINE_SYNC;
    return r;
  endfunction
  // Random image with legal mode codes
  function automatic logic [18:0] mk();
    logic [18:0] r;
    r = 19'(xs());
    r[14:13] = r[14:13] % 2'h3;
    r[16:15] = r[16:15] % 2'h3;
    r[18:17] = r[18:17] % 2'h3;
    return r;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One lever action at a position, then the image is compared
  task automatic tc(input logic [3:0] p, input logic [1:0] d, input int n = 12);
    pos <= p;
    w(4);
    press <= d;
    w(n);
    press <= 2'h0;
    w(16);
    chk(32'(settings_o), 32'(e));
    chk(32'(nvm_wdata_o), 32'(e));
  endtask
  // Avalon transfer: held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge clk_i);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic rst(input logic p, input logic v);
    pal625_i <= p;
    frame_sync_variant_i <= v;
    rst_i <= 1'b1;
    w(3);
    rst_i <= 1'b0;
    w(8);
    e = f_def(p, v);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      n_fail++;
      summarize();
    end
  end
  initial
  begin
    int i;
    logic [18:0] r;
    rst(1'b1, 1'b1);
    chk(32'(settings_o), 32'(e));
    chk(32'(bank_o), 32'(VTOS_BANK_A));
    chk(32'({freeze_active_o, output_black_o, output_mute_o}), 32'h0);
    bus(1'b0, REG_SETTINGS, 32'h0);
    chk(q, 32'(e));
    bus(1'b1, 2'h3, xs());
    bus(1'b1, REG_STATUS, xs());
    bus(1'b0, 2'h2, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h40);
    tc(POS_BANK, DN);
    tc(POS_BANK, DN);
    chk(32'(bank_o), 32'(VTOS_BANK_C));
    for (i = 0; i < 4; i++)
    begin
      e[11:10] = e[11:10] + 2'h1;
      tc(POS_C_TMODE, UP);
    end
    e[12] = 1'b1;
    tc(POS_C_INMODE, UP);
    e[12] = 1'b0;
    tc(POS_C_INMODE, DN);
    for (i = 0; i < 3; i++)
    begin
      e[14:13] = (i == 0) ? FRZ_FIELD2 : FRZ_FRAME;
      tc(POS_C_FRZ, UP);
    end
    input_present_i <= 1'b0;
    w(8);
    chk(32'({output_black_o, output_mute_o}), 32'h2);
    e[16:15] = LOSS_NO_OUTPUT;
    tc(POS_C_LOSS, UP);
    chk(32'({output_black_o, output_mute_o}), 32'h1);
    e[16:15] = LOSS_FREEZE;
    tc(POS_C_LOSS, UP);
    chk(32'({freeze_active_o, output_mute_o}), 32'h2);
    input_present_i <= 1'b1;
    tc(POS_C_FORCE, UP);
    chk(32'(freeze_active_o), 32'h1);
    tc(POS_C_FORCE, DN);
    chk(32'(freeze_active_o), 32'h0);
    tc(POS_C_BLACK, UP);
    chk(32'(output_black_o), 32'h0);
    tc(POS_C_BLACK, UP, 40);
    chk(32'(output_black_o), 32'h1);
    tc(POS_C_BLACK, DN);
    chk(32'(output_black_o), 32'h0);
    e[18:17] = HSW_BLACK;
    tc(POS_C_HOTSW, UP);
    tc(POS_C_MONO, UP, 40);
    chk(32'(force_mono_o), 32'h1);
    tc(POS_C_MONO, DN);
    chk(32'(force_mono_o), 32'h0);
    tc(POS_C_FORCE, UP);
    tc(POS_BANK, UP);
    chk(32'(bank_o), 32'(VTOS_BANK_B));
    e[0] = 1'b0;
    tc(POS_B_SETUP, DN);
    e[1] = 1'b1;
    tc(POS_B_VIBLANK, UP);
    e[7:2] = 6'h15;
    tc(POS_B_VIEND, UP);
    e[7:2] = 6'h14;
    tc(POS_B_VIEND, DN);
    e[8] = 1'b0;
    tc(POS_B_BELOW, DN);
    e[9] = 1'b0;
    tc(POS_B_VBIT, DN);
    tc(POS_C_INMODE, UP);
    ce_i <= 1'b0;
    tc(POS_B_SETUP, UP);
    ce_i <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
      r = (i == 0) ? 19'h00003 : mk();
      bus(1'b1, REG_SETTINGS, 32'(r));
      e = f_fix(r, 1'b1);
      w(3);
      chk(32'(settings_o), 32'(e));
      bus(1'b0, REG_SETTINGS, 32'h0);
      chk(q, 32'(e));
    end
    r = f_fix(mk(), 1'b1);
    nvm_rdata_i <= r;
    nvm_load_i <= 1'b1;
    w(1);
    nvm_load_i <= 1'b0;
    w(4);
    chk(32'(settings_o), 32'(r));
    rst(1'b0, 1'b0);
    chk(32'(settings_o), 32'(e));
    chk(32'(freeze_active_o), 32'h0);
    r = mk();
    r[11:10] = TM_FRAME_DELAY;
    bus(1'b1, REG_SETTINGS, 32'(r));
    e = f_fix(r, 1'b0);
    w(3);
    chk(32'(settings_o), 32'(e));
    summarize();
  end
endmodule
